// ==== inc/tsx_params.svh ====
// Purpose: Constants for the trap, system call, translation and xor unit
// Assumes: 64-bit general registers, 32 translation entries of 256 bits
// Notes:   Opcode and function codes as encoded in the instruction word
`ifndef TSX_PARAMS_SVH
`define TSX_PARAMS_SVH

`define TSX_OP_SPECIAL     6'h00
`define TSX_OP_REGISTER_IMMEDIATE_GROUP      6'h01
`define TSX_OP_XOR_IMMEDIATE_INSTR        6'h0e
`define TSX_OP_SYSTEM_COPROCESSOR_GROUP        6'h10

`define TSX_FN_SYSTEM_CALL_INSTR     6'h0c
`define TSX_FN_TGE         6'h30
`define TSX_FN_TRAP_GE_UNSIGNED_REG        6'h31
`define TSX_FN_TLT         6'h32
`define TSX_FN_TRAP_LT_UNSIGNED_REG        6'h33
`define TSX_FN_TEQ         6'h34
`define TSX_FN_TNE         6'h36
`define TSX_FN_XOR         6'h26

`define TSX_RI_TRAP_GE_SIGNED_IMM        5'h08
`define TSX_RI_TRAP_GE_UNSIGNED_IMM       5'h09
`define TSX_RI_TRAP_LT_SIGNED_IMM        5'h0a
`define TSX_RI_TRAP_LT_UNSIGNED_IMM       5'h0b
`define TSX_RI_TRAP_EQUAL_IMM        5'h0c
`define TSX_RI_TRAP_NOT_EQUAL_IMM        5'h0e

`define TSX_CF_TRANSLATION_READ_INDEXED        6'h01
`define TSX_CF_TRANSLATION_WRITE_INDEXED       6'h02
`define TSX_CF_TRANSLATION_WRITE_RANDOM       6'h06
`define TSX_CF_TRANSLATION_PROBE        6'h08

`define TSX_ENTRIES        32
`define TSX_IDX_W          6
`define TSX_ENT_W          256
`define TSX_G_BIT          140
`define TSX_VPN_HI         167
`define TSX_VPN_LO         141
`define TSX_MASK_HI        216
`define TSX_MASK_LO        205
`define TSX_ADDRESS_SPACE_ID_HI        135
`define TSX_ADDRESS_SPACE_ID_LO        128
`define TSX_PROBE_MISS     32'h8000_0000

`endif

// ==== inc/tsx_pkg.sv ====
// Purpose: Types for the trap, system call, translation and xor unit
// Assumes: Used with tsx_params.svh
// Notes:   None
package tsx_pkg;
  typedef enum logic [1:0] {
    TSX_EXC_NONE,
    TSX_EXC_SYSTEM_CALL_INSTR,
    TSX_EXC_TRAP
  } tsx_exc_t;

  typedef enum logic [2:0] {
    TSX_TLB_NONE,
    TSX_TLB_PROBE,
    TSX_TLB_READ,
    TSX_TLB_WRITE_IDX,
    TSX_TLB_WRITE_RND
  } tsx_tlb_op_t;
endpackage

// ==== rtl/tsx_cmp.sv ====
// Purpose: Trap condition evaluation for register and immediate forms
// Assumes: Operand b already sign-extended where the form needs it
// Notes:   Pure combinational
`timescale 1ns/10ps
`include "tsx_params.svh"
module tsx_cmp (
  input  wire logic [5:0]  sel_i,
  input  wire logic        imm_form_i,
  input  wire logic [63:0] a_i,
  input  wire logic [63:0] b_i,
  output logic             hit_o
);
  logic eq;
  logic lt_s;
  logic lt_u;
  assign eq   = (a_i == b_i);
  assign lt_s = ($signed(a_i) < $signed(b_i));
  assign lt_u = (a_i < b_i);

  always_comb begin
    hit_o = 1'b0;
    if (imm_form_i) begin
      case (sel_i[4:0])
        `TSX_RI_TRAP_EQUAL_IMM:  hit_o = eq;
        `TSX_RI_TRAP_NOT_EQUAL_IMM:  hit_o = !eq;
        `TSX_RI_TRAP_GE_SIGNED_IMM:  hit_o = !lt_s;
        `TSX_RI_TRAP_LT_SIGNED_IMM:  hit_o = lt_s;
        `TSX_RI_TRAP_GE_UNSIGNED_IMM: hit_o = !lt_u;
        `TSX_RI_TRAP_LT_UNSIGNED_IMM: hit_o = lt_u;
        default:       hit_o = 1'b0;
      endcase
    end else begin
      case (sel_i)
        `TSX_FN_TEQ:  hit_o = eq;
        `TSX_FN_TNE:  hit_o = !eq;
        `TSX_FN_TGE:  hit_o = !lt_s;
        `TSX_FN_TLT:  hit_o = lt_s;
        `TSX_FN_TRAP_GE_UNSIGNED_REG: hit_o = !lt_u;
        `TSX_FN_TRAP_LT_UNSIGNED_REG: hit_o = lt_u;
        default:      hit_o = 1'b0;
      endcase
    end
  end
endmodule

// ==== rtl/tsx_probe.sv ====
// Purpose: Associative probe of the translation entries
// Assumes: Entries flattened, entry i at bits [i*256 +: 256]
// Notes:   Lowest matching entry wins; multiple match is unspecified
`timescale 1ns/10ps
`include "tsx_params.svh"
module tsx_probe (
  input  wire logic [`TSX_ENTRIES*`TSX_ENT_W-1:0] ents_i,
  input  wire logic [63:0]                        vpage_i,
  output logic [31:0]                             index_o
);
  function automatic logic match(input logic [`TSX_ENT_W-1:0] e, input logic [63:0] vp);
    logic [26:0] msk;
    msk = {15'h0000, e[`TSX_MASK_HI:`TSX_MASK_LO]};
    match = (((e[`TSX_VPN_HI:`TSX_VPN_LO] & ~msk) == (vp[39:13] & ~msk)) &&
             (e[`TSX_G_BIT] || (e[`TSX_ADDRESS_SPACE_ID_HI:`TSX_ADDRESS_SPACE_ID_LO] == vp[7:0])));
  endfunction

  always_comb begin
    index_o = `TSX_PROBE_MISS;
    for (int i = `TSX_ENTRIES - 1; i >= 0; i--) begin
      if (match(ents_i[i*`TSX_ENT_W +: `TSX_ENT_W], vpage_i)) begin
        index_o = {26'h000_0000, 6'(i)};
      end
    end
  end
endmodule

// ==== rtl/tsx_exec.sv ====
// Purpose: Decode and execute for system call, traps, translation ops and xor
// Assumes: Operands from the register file are valid in the cycle of valid_i
// Notes:   One instruction per enabled cycle; results registered one cycle later
//
// Notes on behaviour
// - System-call function code raises a system-call exception unconditionally.
// - Code fields of system call and register traps are ignored by hardware.
// - Equal and not-equal register traps compare both source registers.
// - Signed greater-or-equal register trap fires when first source >= second.
// - Signed less-than register trap fires when first source < second.
// - Unsigned traps compare unsigned; immediate forms still sign-extend first.
// - Immediate traps pick condition by second field; immediate sign-extended.
// - Probe loads index of matching entry, else sets index top bit.
// - Match needs masked page number equal and global or same space id.
// - Multiple matches and memory access right after probe are unspecified.
// - Indexed read loads mask, page and both physical regs, global copied.
// - Indexed access uses low five index bits; beyond entries is unspecified.
// - Indexed write stores mask, masked page, physical regs, global is AND.
// - Random write stores same contents at entry from random register.
// - Register xor writes source xor into destination, no exception.
// - Immediate xor zero-extends, writes second register field, no exception.
`timescale 1ns/10ps
`include "tsx_params.svh"
module tsx_exec (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [63:0] src_a_i,
  input  wire logic [63:0] src_b_i,
  input  wire logic [31:0] index_reg_i,
  input  wire logic [31:0] random_reg_i,
  input  wire logic [63:0] page_mask_i,
  input  wire logic [63:0] virtual_page_reg_i,
  input  wire logic [63:0] even_physical_page_reg_i,
  input  wire logic [63:0] odd_physical_page_reg_i,
  output logic             wb_en_o,
  output logic [4:0]       wb_addr_o,
  output logic [63:0]      wb_data_o,
  output tsx_pkg::tsx_exc_t exc_o,
  output logic             flush_o,
  output logic             index_we_o,
  output logic [31:0]      index_o,
  output logic             tlb_rd_we_o,
  output logic [63:0]      page_mask_o,
  output logic [63:0]      virtual_page_reg_o,
  output logic [63:0]      even_physical_page_reg_o,
  output logic [63:0]      odd_physical_page_reg_o
);
  logic [`TSX_ENT_W-1:0]               ents_r [`TSX_ENTRIES];
  logic [`TSX_ENTRIES*`TSX_ENT_W-1:0]  ents_flat;
  logic [5:0]                          opc;
  logic [5:0]                          fn;
  logic [4:0]                          first_source_field;
  logic [4:0]                          second_register_field;
  logic [4:0]                          dest_field;
  logic [63:0]                         imm_sx;
  logic [63:0]                         imm_zx;
  logic                                is_special;
  logic                                is_register_immediate_group;
  logic                                is_system_coprocessor_group_co;
  logic                                cmp_imm;
  logic [5:0]                          cmp_sel;
  logic [63:0]                         cmp_b;
  logic                                trap_hit;
  logic                                is_trap;
  logic                                is_system_call_instr;
  logic [31:0]                         probe_idx;
  logic [`TSX_ENT_W-1:0]               new_ent;
  logic [`TSX_ENT_W-1:0]               rd_ent;
  tsx_pkg::tsx_tlb_op_t                tlb_op;
  tsx_pkg::tsx_exc_t                   exc_nxt;

  // Instruction fields; code fields simply never read
  assign opc                   = instr_i[31:26];
  assign fn                    = instr_i[5:0];
  assign first_source_field    = instr_i[25:21];
  assign second_register_field = instr_i[20:16];
  assign dest_field            = instr_i[15:11];
  assign imm_sx                = {{48{instr_i[15]}}, instr_i[15:0]};
  assign imm_zx                = {48'h0000_0000_0000, instr_i[15:0]};
  assign is_special            = valid_i && (opc == `TSX_OP_SPECIAL);
  assign is_register_immediate_group             = valid_i && (opc == `TSX_OP_REGISTER_IMMEDIATE_GROUP);
  assign is_system_coprocessor_group_co            = valid_i && (opc == `TSX_OP_SYSTEM_COPROCESSOR_GROUP) && instr_i[25];

  assign cmp_imm = is_register_immediate_group;
  assign cmp_sel = is_register_immediate_group ? {1'b0, second_register_field} : fn;
  assign cmp_b   = is_register_immediate_group ? imm_sx : src_b_i;

  tsx_cmp u_cmp (
    .sel_i      (cmp_sel),
    .imm_form_i (cmp_imm),
    .a_i        (src_a_i),
    .b_i        (cmp_b),
    .hit_o      (trap_hit)
  );

  assign is_trap    = (is_special || is_register_immediate_group) && trap_hit;
  assign is_system_call_instr = is_special && (fn == `TSX_FN_SYSTEM_CALL_INSTR);

  always_comb begin
    exc_nxt = tsx_pkg::TSX_EXC_NONE;
    if (is_system_call_instr) begin
      exc_nxt = tsx_pkg::TSX_EXC_SYSTEM_CALL_INSTR;
    end else if (is_trap) begin
      exc_nxt = tsx_pkg::TSX_EXC_TRAP;
    end
  end

  always_comb begin
    tlb_op = tsx_pkg::TSX_TLB_NONE;
    if (is_system_coprocessor_group_co) begin
      case (fn)
        `TSX_CF_TRANSLATION_PROBE:  tlb_op = tsx_pkg::TSX_TLB_PROBE;
        `TSX_CF_TRANSLATION_READ_INDEXED:  tlb_op = tsx_pkg::TSX_TLB_READ;
        `TSX_CF_TRANSLATION_WRITE_INDEXED: tlb_op = tsx_pkg::TSX_TLB_WRITE_IDX;
        `TSX_CF_TRANSLATION_WRITE_RANDOM: tlb_op = tsx_pkg::TSX_TLB_WRITE_RND;
        default:       tlb_op = tsx_pkg::TSX_TLB_NONE;
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < `TSX_ENTRIES; i++) begin
      ents_flat[i*`TSX_ENT_W +: `TSX_ENT_W] = ents_r[i];
    end
  end

  // Lowest match wins; several matches are left unspecified
  tsx_probe u_probe (
    .ents_i   (ents_flat),
    .vpage_i  (virtual_page_reg_i),
    .index_o  (probe_idx)
  );

  // Entry image; global bit is the AND of both physical globals
  always_comb begin
    new_ent = {page_mask_i,
               virtual_page_reg_i & ~page_mask_i,
               odd_physical_page_reg_i[63:1],
               1'b0,
               even_physical_page_reg_i[63:1],
               1'b0};
    new_ent[`TSX_G_BIT] = even_physical_page_reg_i[0] & odd_physical_page_reg_i[0];
  end

  // Only 32 entries: index bit 5 aliases, beyond range is unspecified
  assign rd_ent = ents_r[index_reg_i[4:0]];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (tlb_op == tsx_pkg::TSX_TLB_WRITE_IDX) begin
        ents_r[index_reg_i[4:0]] <= new_ent;
      end else if (tlb_op == tsx_pkg::TSX_TLB_WRITE_RND) begin
        ents_r[random_reg_i[4:0]] <= new_ent;
      end
    end
  end

  // Exception outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exc_o   <= tsx_pkg::TSX_EXC_NONE;
      flush_o <= 1'b0;
    end else if (ce_i) begin
      exc_o   <= exc_nxt;
      flush_o <= (exc_nxt != tsx_pkg::TSX_EXC_NONE);
    end
  end

  // Register writeback; suppressed by any exception
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_en_o   <= 1'b0;
      wb_addr_o <= 5'h00;
      wb_data_o <= 64'h0000_0000_0000_0000;
    end else if (ce_i) begin
      wb_en_o <= 1'b0;
      if (exc_nxt == tsx_pkg::TSX_EXC_NONE) begin
        if (is_special && fn == `TSX_FN_XOR) begin
          wb_en_o   <= 1'b1;
          wb_addr_o <= dest_field;
          wb_data_o <= src_a_i ^ src_b_i;
        end else if (valid_i && opc == `TSX_OP_XOR_IMMEDIATE_INSTR) begin
          wb_en_o   <= 1'b1;
          wb_addr_o <= second_register_field;
          wb_data_o <= src_a_i ^ imm_zx;
        end
      end
    end
  end

  // Probe result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_we_o <= 1'b0;
      index_o    <= 32'h0000_0000;
    end else if (ce_i) begin
      index_we_o <= (tlb_op == tsx_pkg::TSX_TLB_PROBE);
      if (tlb_op == tsx_pkg::TSX_TLB_PROBE) begin
        index_o <= probe_idx;
      end
    end
  end

  // Indexed read into the translation registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tlb_rd_we_o              <= 1'b0;
      page_mask_o              <= 64'h0000_0000_0000_0000;
      virtual_page_reg_o       <= 64'h0000_0000_0000_0000;
      even_physical_page_reg_o <= 64'h0000_0000_0000_0000;
      odd_physical_page_reg_o  <= 64'h0000_0000_0000_0000;
    end else if (ce_i) begin
      tlb_rd_we_o <= (tlb_op == tsx_pkg::TSX_TLB_READ);
      if (tlb_op == tsx_pkg::TSX_TLB_READ) begin
        page_mask_o              <= rd_ent[255:192];
        virtual_page_reg_o       <= rd_ent[191:128] & ~rd_ent[255:192];
        odd_physical_page_reg_o  <= {rd_ent[127:65], rd_ent[`TSX_G_BIT]};
        even_physical_page_reg_o <= {rd_ent[63:1], rd_ent[`TSX_G_BIT]};
      end
    end
  end

  // Checks
  system_call_instr_exc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_system_call_instr) |=> (exc_o == tsx_pkg::TSX_EXC_SYSTEM_CALL_INSTR) && flush_o)
    else $error("system call did not raise exception");
  trap_nowb_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (exc_o != tsx_pkg::TSX_EXC_NONE) |-> !wb_en_o)
    else $error("excepting instruction wrote a register");
  teq_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_special && fn == `TSX_FN_TEQ && src_a_i == src_b_i) |=> exc_o == tsx_pkg::TSX_EXC_TRAP)
    else $error("equal trap missed");
  tge_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_special && fn == `TSX_FN_TGE) |=>
      ((exc_o == tsx_pkg::TSX_EXC_TRAP) == ($signed($past(src_a_i)) >= $signed($past(src_b_i)))))
    else $error("signed ge trap wrong");
  tlt_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_special && fn == `TSX_FN_TLT) |=>
      ((exc_o == tsx_pkg::TSX_EXC_TRAP) == ($signed($past(src_a_i)) < $signed($past(src_b_i)))))
    else $error("signed lt trap wrong");
  trap_lt_unsigned_imm_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_register_immediate_group && second_register_field == `TSX_RI_TRAP_LT_UNSIGNED_IMM) |=>
      ((exc_o == tsx_pkg::TSX_EXC_TRAP) == ($past(src_a_i) < $past(imm_sx))))
    else $error("unsigned immediate lt trap wrong");
  probe_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && tlb_op == tsx_pkg::TSX_TLB_PROBE) |=> index_we_o && index_o == $past(probe_idx))
    else $error("probe result not loaded");
  xor_wb_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_special && fn == `TSX_FN_XOR) |=> wb_en_o && wb_data_o == ($past(src_a_i) ^ $past(src_b_i)))
    else $error("register xor result wrong");
  xor_immediate_instr_wb_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && valid_i && opc == `TSX_OP_XOR_IMMEDIATE_INSTR) |=> wb_en_o && wb_addr_o == $past(second_register_field))
    else $error("immediate xor destination wrong");
  trap_equal_imm_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_register_immediate_group && second_register_field == `TSX_RI_TRAP_EQUAL_IMM) |=>
      ((exc_o == tsx_pkg::TSX_EXC_TRAP) == ($past(src_a_i) == $past(imm_sx))))
    else $error("equal immediate trap wrong");
  xor_noexc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && is_special && fn == `TSX_FN_XOR) |=> exc_o == tsx_pkg::TSX_EXC_NONE && !flush_o)
    else $error("register xor raised exception");
  translation_read_indexed_global_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && tlb_op == tsx_pkg::TSX_TLB_READ) |=>
      tlb_rd_we_o && (even_physical_page_reg_o[0] == odd_physical_page_reg_o[0]))
    else $error("global bit not copied to both physical registers");
  // Frozen outputs while enable is low keep the pipeline stall safe
  ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ce_i) |=> $stable(wb_en_o) && $stable(exc_o) && $stable(wb_data_o) && $stable(index_o))
    else $error("state moved while enable low");
endmodule

// ==== dv/tsx_exec_bench.sv ====
// Purpose: Self-checking bench for the trap, system call, translation and xor unit
// Assumes: One cycle latency; outputs sampled 1 ns after the taking edge
// Notes:   Translation array filled first, it has no reset and X entries would spoil probes
`timescale 1ns/10ps
`include "tsx_params.svh"
module tsx_exec_bench;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              ce_i = 1'b1;
  logic              valid_i = 1'b0;
  logic [31:0]       instr_i = 32'h0;
  logic [63:0]       src_a_i = 64'h0;
  logic [63:0]       src_b_i = 64'h0;
  logic [31:0]       index_reg_i = 32'h0;
  logic [31:0]       random_reg_i = 32'h0;
  logic [63:0]       page_mask_i = 64'h0;
  logic [63:0]       virtual_page_reg_i = 64'h0;
  logic [63:0]       even_physical_page_reg_i = 64'h0;
  logic [63:0]       odd_physical_page_reg_i = 64'h0;
  logic              wb_en_o;
  logic [4:0]        wb_addr_o;
  logic [63:0]       wb_data_o;
  tsx_pkg::tsx_exc_t exc_o;
  logic              flush_o;
  logic              index_we_o;
  logic [31:0]       index_o;
  logic              tlb_rd_we_o;
  logic [63:0]       page_mask_o;
  logic [63:0]       virtual_page_reg_o;
  logic [63:0]       even_physical_page_reg_o;
  logic [63:0]       odd_physical_page_reg_o;
  int                bad_count = 0;
  int                total_checks = 0;
  int                cycles = 0;

  always #50 clk_i = ~clk_i;

  tsx_exec tsx_exec_inst (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .ce_i                     (ce_i),
    .valid_i                  (valid_i),
    .instr_i                  (instr_i),
    .src_a_i                  (src_a_i),
    .src_b_i                  (src_b_i),
    .index_reg_i              (index_reg_i),
    .random_reg_i             (random_reg_i),
    .page_mask_i              (page_mask_i),
    .virtual_page_reg_i       (virtual_page_reg_i),
    .even_physical_page_reg_i (even_physical_page_reg_i),
    .odd_physical_page_reg_i  (odd_physical_page_reg_i),
    .wb_en_o                  (wb_en_o),
    .wb_addr_o                (wb_addr_o),
    .wb_data_o                (wb_data_o),
    .exc_o                    (exc_o),
    .flush_o                  (flush_o),
    .index_we_o               (index_we_o),
    .index_o                  (index_o),
    .tlb_rd_we_o              (tlb_rd_we_o),
    .page_mask_o              (page_mask_o),
    .virtual_page_reg_o       (virtual_page_reg_o),
    .even_physical_page_reg_o (even_physical_page_reg_o),
    .odd_physical_page_reg_o  (odd_physical_page_reg_o)
  );

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Valid stays up between calls so back-to-back issue never toggles it twice in a step
  task automatic run_op(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
    instr_i = ins;
    src_a_i = a;
    src_b_i = b;
    valid_i = 1'b1;
    @(posedge clk_i);
    #1;
  endtask

  task automatic idle;
    valid_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic set_tlb(input logic [63:0] m, input logic [63:0] vp, input logic [63:0] ev,
                         input logic [63:0] od);
    page_mask_i = m;
    virtual_page_reg_i = vp;
    even_physical_page_reg_i = ev;
    odd_physical_page_reg_i = od;
  endtask

  // Exceptions never write back: precise handling
  task automatic chk_exc(input tsx_pkg::tsx_exc_t e);
    chk(exc_o, e);
    chk(flush_o, e != tsx_pkg::TSX_EXC_NONE);
    chk(wb_en_o, 1'b0);
  endtask

  function automatic logic trap_hit(input logic [2:0] k, input logic [63:0] a, input logic [63:0] b);
    case (k)
      3'h0: return $signed(a) >= $signed(b);
      3'h1: return a >= b;
      3'h2: return $signed(a) < $signed(b);
      3'h3: return a < b;
      3'h4: return a == b;
      3'h6: return a != b;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] cp0(input logic [5:0] f);
    return {6'h10, 1'b1, 19'h0, f};
  endfunction

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    logic [63:0] av [4];
    logic [15:0] bv [4];
    logic [5:0]  fnv [6];
    logic [63:0] b;
    logic        h;
    av = '{64'h5, 64'hFFFF_FFFF_FFFF_FFFF, 64'h1, 64'h8000_0000_0000_0000};
    bv = '{16'h0005, 16'h0001, 16'hFFFF, 16'hFFFE};
    fnv = '{`TSX_FN_TGE, `TSX_FN_TRAP_GE_UNSIGNED_REG, `TSX_FN_TLT, `TSX_FN_TRAP_LT_UNSIGNED_REG, `TSX_FN_TEQ, `TSX_FN_TNE};
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    chk_exc(tsx_pkg::TSX_EXC_NONE);
    chk(index_we_o, 1'b0);
    chk(tlb_rd_we_o, 1'b0);
    $display("test reset done");
    // Code fields nonzero: hardware must ignore them
    run_op({`TSX_OP_SPECIAL, 20'hABCDE, `TSX_FN_SYSTEM_CALL_INSTR}, 64'h0, 64'h0);
    chk_exc(tsx_pkg::TSX_EXC_SYSTEM_CALL_INSTR);
    run_op({`TSX_OP_SPECIAL, 5'd3, 5'd4, 5'd9, 5'd0, `TSX_FN_XOR}, 64'hDEAD_BEEF_0123_4567,
           64'h0F0F_0F0F_F0F0_F0F0);
    chk(wb_en_o, 1'b1);
    chk(wb_addr_o, 5'd9);
    chk(wb_data_o, 64'hD1A2_B1E0_F1D3_B597);
    chk(exc_o, tsx_pkg::TSX_EXC_NONE);
    run_op({`TSX_OP_XOR_IMMEDIATE_INSTR, 5'd3, 5'd12, 16'h8001}, 64'hFFFF_FFFF_FFFF_FFFF, 64'h1234_5678);
    chk(wb_addr_o, 5'd12);
    chk(wb_data_o, 64'hFFFF_FFFF_FFFF_7FFE);
    chk(exc_o, tsx_pkg::TSX_EXC_NONE);
    $display("test system_call_instr and xor done");
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 4; j++) begin
        b = {{48{bv[j][15]}}, bv[j]};
        h = trap_hit(fnv[k][2:0], av[j], b);
        run_op({`TSX_OP_SPECIAL, 5'd3, 5'd4, 10'h2A5, fnv[k]}, av[j], b);
        chk_exc(h ? tsx_pkg::TSX_EXC_TRAP : tsx_pkg::TSX_EXC_NONE);
        // Register operand b is garbage here, the immediate must win
        run_op({`TSX_OP_REGISTER_IMMEDIATE_GROUP, 5'd3, {2'b01, fnv[k][2:0]}, bv[j]}, av[j], ~b);
        chk_exc(h ? tsx_pkg::TSX_EXC_TRAP : tsx_pkg::TSX_EXC_NONE);
      end
    end
    $display("test traps done");
    idle();
    run_op({`TSX_OP_SPECIAL, 5'd3, 5'd4, 5'd9, 5'd0, `TSX_FN_XOR}, 64'h1, 64'h2);
    chk(wb_data_o, 64'h3);
    ce_i = 1'b0;
    run_op({`TSX_OP_SPECIAL, 5'd3, 5'd4, 5'd7, 5'd0, `TSX_FN_XOR}, 64'h4, 64'h8);
    chk(wb_en_o, 1'b1);
    chk(wb_addr_o, 5'd9);
    chk(wb_data_o, 64'h3);
    ce_i = 1'b1;
    idle();
    chk(wb_en_o, 1'b0);
    $display("test clock enable done");
    for (int i = 0; i < 32; i++) begin
      index_reg_i = i;
      set_tlb(64'h0, 64'h0000_00F0_0000_00EE | (64'(i) << 13), 64'h0, 64'h0);
      run_op(cp0(`TSX_CF_TRANSLATION_WRITE_INDEXED), 64'h0, 64'h0);
    end
    index_reg_i = 32'h3;
    set_tlb(64'h6000, 64'h0000_0012_3456_6042, 64'h0000_0000_0ABC_0001, 64'h0000_0000_0DEF_0000);
    run_op(cp0(`TSX_CF_TRANSLATION_WRITE_INDEXED), 64'h0, 64'h0);
    set_tlb(64'h0, 64'h0000_0012_3456_4042, 64'h0, 64'h0);
    run_op(cp0(`TSX_CF_TRANSLATION_PROBE), 64'h0, 64'h0);
    chk(index_we_o, 1'b1);
    chk(index_o, 32'h0000_0003);
    set_tlb(64'h0, 64'h0000_0012_3456_6043, 64'h0, 64'h0);
    run_op(cp0(`TSX_CF_TRANSLATION_PROBE), 64'h0, 64'h0);
    chk(index_o, `TSX_PROBE_MISS);
    set_tlb(64'h0, 64'h0000_0012_3446_6042, 64'h0, 64'h0);
    run_op(cp0(`TSX_CF_TRANSLATION_PROBE), 64'h0, 64'h0);
    chk(index_o, `TSX_PROBE_MISS);
    random_reg_i = 32'h7;
    set_tlb(64'h0, 64'h0000_0055_0000_1011, 64'h0000_0000_0000_00F1, 64'h0000_0000_0000_0303);
    run_op(cp0(`TSX_CF_TRANSLATION_WRITE_RANDOM), 64'h0, 64'h0);
    set_tlb(64'h0, 64'h0000_0055_0000_1099, 64'h0, 64'h0);
    run_op(cp0(`TSX_CF_TRANSLATION_PROBE), 64'h0, 64'h0);
    chk(index_o, 32'h0000_0007);
    index_reg_i = 32'h7;
    run_op(cp0(`TSX_CF_TRANSLATION_READ_INDEXED), 64'h0, 64'h0);
    chk(tlb_rd_we_o, 1'b1);
    chk(page_mask_o, 64'h0);
    chk(virtual_page_reg_o, 64'h0000_0055_0000_1011);
    chk(even_physical_page_reg_o, 64'h0000_0000_0000_00F1);
    chk(odd_physical_page_reg_o, 64'h0000_0000_0000_0303);
    index_reg_i = 32'h3;
    run_op(cp0(`TSX_CF_TRANSLATION_READ_INDEXED), 64'h0, 64'h0);
    chk(page_mask_o, 64'h6000);
    chk(virtual_page_reg_o, 64'h0000_0012_3456_0042);
    chk(even_physical_page_reg_o, 64'h0000_0000_0ABC_0000);
    chk(odd_physical_page_reg_o, 64'h0000_0000_0DEF_0000);
    idle();
    chk(tlb_rd_we_o, 1'b0);
    $display("test translation done");
    complete_run();
  end
endmodule
